// [hw/fmd_pkg.sv]
// Package of the fault mask and diagnostic status block.
// Assumes an 8-bit register port driven by the device's serial front end.
`default_nettype none

package fmd_pkg;

    // =====================================================================
    // Register offsets
    localparam logic [7:0] OFS_OPEN_FLAGS = 8'h1B;
    localparam logic [7:0] OFS_GND_FLAGS = 8'h1C;
    localparam logic [7:0] OFS_SHORT_FLAGS = 8'h1D;
    localparam logic [7:0] OFS_FAULT_PIN_MASK = 8'h1E;
    localparam logic [7:0] OFS_DIAGNOSTIC_STATUS = 8'h1F;

    // =====================================================================
    // Field positions of the mask register
    localparam int MSK_LED_SHORT = 0;
    localparam int MSK_THERMAL_WARN = 1;
    localparam int MSK_GROUND_SHORT = 2;
    localparam int MSK_OPEN_STRING = 3;
    localparam int MSK_BOOST_FAULT = 4;
    localparam int MSK_WIDTH = 5;

    // =====================================================================
    // Field positions of the diagnostic status register
    localparam int DG_THERMAL_SHUTDOWN = 0;
    localparam int DG_THERMAL_WARN = 1;
    localparam int DG_POWERUP = 2;
    localparam int DG_BOOST_OVERVOLT = 3;
    localparam int DG_BOOST_UNDERVOLT = 4;
    localparam int DG_REF_RANGE = 5;

    // =====================================================================
    // Values after reset
    localparam logic [4:0] RST_FAULT_PIN_MASK = 5'h00;
    localparam logic RST_POWERUP_FLAG = 1'b1;
    localparam logic RST_LATCHED_FLAG = 1'b0;
    localparam logic [3:0] RST_CHANNEL_FLAGS = 4'h0;
    localparam logic [7:0] RST_READ_DATA = 8'h00;

    // =====================================================================
    // Sizes
    localparam int NUM_CHANNELS = 4;
    localparam int SYNC_STAGES = 2;

endpackage

`default_nettype wire

// [hw/fmd_sync.sv]
// Two-flip-flop synchroniser bank for the analog comparator and pin inputs.
// Assumes inputs are asynchronous levels; outputs are on the system clock.
`default_nettype none

module fmd_sync #(
    parameter int WIDTH = 1
) (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic srst,
    // Asynchronous levels in
    input wire logic [WIDTH-1:0] async_in,
    // Synchronised levels out
    output logic [WIDTH-1:0] sync_out
);

    // =====================================================================
    // Synchroniser chain
    logic [WIDTH-1:0] meta_ff;
    logic [WIDTH-1:0] stable_ff;

    // The first stage feeds only the second stage, to contain metastability.
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            meta_ff <= '0;
            stable_ff <= '0;
        end else begin
            meta_ff <= async_in;
            stable_ff <= meta_ff;
        end
    end

    // Output straight from the second stage.
    assign sync_out = stable_ff;

endmodule

`default_nettype wire

// [hw/fmd_top.sv]
// Fault pin masking and diagnostic status logic of a four-channel LED driver.
// Assumes a same-clock register port from the serial front end and raw
// comparator levels from the analog detectors, which are asynchronous.
//
// Contract
// - A set boost-fault gate keeps boost undervoltage and overvoltage off the fault line.
// - A set open-string gate keeps an open LED string off the fault line.
// - A set ground-short gate keeps a string shorted to ground off the fault line.
// - A set thermal-warning gate keeps the thermal warning off the fault line.
// - A set LED-short gate keeps a shorted LED on any channel off the fault line.
// - All five gate bits are read-write and reset to zero.
// - Status bit 5 is set when the reference current is out of range and operation halts.
// - Status bit 4 is set on boost undervoltage and the boost is disabled at once.
// - Status bit 3 reads one while the boost sits at its overvoltage limit.
// - Status bit 2 is one after reset and clears after the first status read.
// - Status bit 1 reads one while the junction is above 125 C.
// - Above 165 C the device shuts down and status bit 0 reads one.
// - The open-string class comes from four read-only per-channel open flags in bits 0 to 3.
// - The ground-short class comes from per-channel flags set only during startup.
// - The LED-short class comes from four read-only per-channel shorted-LED flags.
`default_nettype none

module fmd_top #(
    parameter int NUM_CH = fmd_pkg::NUM_CHANNELS
) (
    // Clock and reset
    input wire logic CLK_SYS,
    input wire logic SRST,
    // Register port from the serial front end
    input wire logic [7:0] REG_ADDR,
    input wire logic REG_WR,
    input wire logic [7:0] REG_WDATA,
    input wire logic REG_RD,
    output logic [7:0] REG_RDATA,
    output logic REG_RDATA_VALID,
    // Comparator levels from the analog detectors
    input wire logic REF_CURRENT_BAD,
    input wire logic BOOST_UNDERVOLT_DET,
    input wire logic BOOST_OVERVOLT_DET,
    input wire logic TEMP_ABOVE_WARN,
    input wire logic TEMP_ABOVE_SHUTDOWN,
    input wire logic STARTUP_PHASE,
    input wire logic [NUM_CH-1:0] CH_OPEN_DET,
    input wire logic [NUM_CH-1:0] CH_GND_SHORT_DET,
    input wire logic [NUM_CH-1:0] CH_LED_SHORT_DET,
    // Open-drain fault line
    input wire logic FAULT_LINE_N_I,
    output logic FAULT_LINE_N_O,
    output logic FAULT_LINE_N_OE,
    output logic FAULT_LINE_SENSE,
    // Power control towards the analog core
    output logic HALT_OPERATION,
    output logic BOOST_DISABLE,
    output logic THERMAL_SHUTDOWN
);

    // =====================================================================
    // Input synchronisation
    localparam int SYNC_W = 7 + 3 * NUM_CH;

    logic [SYNC_W-1:0] raw_in;
    logic [SYNC_W-1:0] syn_in;
    logic ref_bad_s, boost_uv_s, boost_ov_s, temp_warn_s, temp_crit_s, startup_s, line_s;
    logic [NUM_CH-1:0] open_s, gnd_s, lshort_s;

    // Gather every asynchronous level into one bank; the reference flag sits at the top.
    assign raw_in = {REF_CURRENT_BAD, FAULT_LINE_N_I, CH_LED_SHORT_DET, CH_GND_SHORT_DET,
                     CH_OPEN_DET, STARTUP_PHASE, TEMP_ABOVE_SHUTDOWN, TEMP_ABOVE_WARN,
                     BOOST_OVERVOLT_DET, BOOST_UNDERVOLT_DET};
    // Every pin level passes the same two-stage chain before any logic reads it.
    fmd_sync #(
        .WIDTH(SYNC_W)
    ) u_sync (
        .clk_sys(CLK_SYS),
        .srst(SRST),
        .async_in(raw_in),
        .sync_out(syn_in)
    );

    // Split the synchronised bank back into named levels.
    assign boost_uv_s = syn_in[0];
    assign boost_ov_s = syn_in[1];
    assign temp_warn_s = syn_in[2];
    assign temp_crit_s = syn_in[3];
    assign startup_s = syn_in[4];
    assign open_s = syn_in[5 +: NUM_CH];
    assign gnd_s = syn_in[5 + NUM_CH +: NUM_CH];
    assign lshort_s = syn_in[5 + 2 * NUM_CH +: NUM_CH];
    assign line_s = syn_in[5 + 3 * NUM_CH];
    assign ref_bad_s = syn_in[SYNC_W-1];

    // =====================================================================
    // Register port decode
    logic wr_mask;
    logic rd_diagnostic_status;

    // Decode helper shared by the write and read paths.
    function automatic logic hit(input logic [7:0] addr, input logic [7:0] ofs);
        hit = (addr == ofs);
    endfunction

    assign wr_mask = REG_WR && hit(REG_ADDR, fmd_pkg::OFS_FAULT_PIN_MASK);
    assign rd_diagnostic_status = REG_RD && hit(REG_ADDR, fmd_pkg::OFS_DIAGNOSTIC_STATUS);

    // =====================================================================
    // Fault pin mask register
    logic [fmd_pkg::MSK_WIDTH-1:0] mask_ff;

    always_ff @(posedge CLK_SYS) begin
        if (SRST) begin
            mask_ff <= fmd_pkg::RST_FAULT_PIN_MASK;
        end else if (wr_mask) begin
            mask_ff <= REG_WDATA[fmd_pkg::MSK_WIDTH-1:0];
        end
    end

    // =====================================================================
    // Per-channel diagnostic flags
    logic [NUM_CH-1:0] open_ff, gnd_ff, lshort_ff;

    always_ff @(posedge CLK_SYS) begin
        if (SRST) begin
            open_ff <= fmd_pkg::RST_CHANNEL_FLAGS;
            lshort_ff <= fmd_pkg::RST_CHANNEL_FLAGS;
        end else begin
            open_ff <= open_s;
            lshort_ff <= lshort_s;
        end
    end

    // startup-only ground flags
    // Ground-short flags are captured only during startup and then held until reset.
    always_ff @(posedge CLK_SYS) begin
        if (SRST) begin
            gnd_ff <= fmd_pkg::RST_CHANNEL_FLAGS;
        end else if (startup_s) begin
            gnd_ff <= gnd_ff | gnd_s;
        end
    end

    // =====================================================================
    // Diagnostic status flags
    logic ref_bad_ff, boost_uv_ff, boost_ov_ff, powerup_ff, temp_warn_ff, shutdown_ff;

    always_ff @(posedge CLK_SYS) begin
        if (SRST) begin
            ref_bad_ff <= fmd_pkg::RST_LATCHED_FLAG;
            boost_ov_ff <= fmd_pkg::RST_LATCHED_FLAG;
            temp_warn_ff <= fmd_pkg::RST_LATCHED_FLAG;
        end else begin
            ref_bad_ff <= ref_bad_s;
            boost_ov_ff <= boost_ov_s;
            temp_warn_ff <= temp_warn_s;
        end
    end

    // undervoltage latch
    // The boost stays disabled until reset once an undervoltage is seen.
    always_ff @(posedge CLK_SYS) begin
        if (SRST) begin
            boost_uv_ff <= fmd_pkg::RST_LATCHED_FLAG;
        end else if (boost_uv_s) begin
            boost_uv_ff <= 1'b1;
        end
    end

    // thermal shutdown latch
    // Shutdown is held until reset so the core cannot restart hot.
    always_ff @(posedge CLK_SYS) begin
        if (SRST) begin
            shutdown_ff <= fmd_pkg::RST_LATCHED_FLAG;
        end else if (temp_crit_s) begin
            shutdown_ff <= 1'b1;
        end
    end

    // powerup flag clear
    // The flag comes up set and drops after the first read of the status.
    always_ff @(posedge CLK_SYS) begin
        if (SRST) begin
            powerup_ff <= fmd_pkg::RST_POWERUP_FLAG;
        end else if (rd_diagnostic_status) begin
            powerup_ff <= 1'b0;
        end
    end

    // =====================================================================
    // Read data path
    logic [7:0] diagnostic_status_word;
    logic [7:0] nxt_rdata;

    // Assemble the status register; reserved bits read as zero.
    always_comb begin
        diagnostic_status_word = 8'h00;
        diagnostic_status_word[fmd_pkg::DG_REF_RANGE] = ref_bad_ff;
        diagnostic_status_word[fmd_pkg::DG_BOOST_UNDERVOLT] = boost_uv_ff;
        diagnostic_status_word[fmd_pkg::DG_BOOST_OVERVOLT] = boost_ov_ff;
        diagnostic_status_word[fmd_pkg::DG_POWERUP] = powerup_ff;
        diagnostic_status_word[fmd_pkg::DG_THERMAL_WARN] = temp_warn_ff;
        diagnostic_status_word[fmd_pkg::DG_THERMAL_SHUTDOWN] = shutdown_ff;
    end

    // Select read data; an unmapped offset reads as zero.
    always_comb begin
        nxt_rdata = 8'h00;
        case (REG_ADDR)
            fmd_pkg::OFS_OPEN_FLAGS: begin
                nxt_rdata[NUM_CH-1:0] = open_ff;
            end
            fmd_pkg::OFS_GND_FLAGS: begin
                nxt_rdata[NUM_CH-1:0] = gnd_ff;
            end
            fmd_pkg::OFS_SHORT_FLAGS: begin
                nxt_rdata[NUM_CH-1:0] = lshort_ff;
            end
            fmd_pkg::OFS_FAULT_PIN_MASK: begin
                nxt_rdata[fmd_pkg::MSK_WIDTH-1:0] = mask_ff;
            end
            fmd_pkg::OFS_DIAGNOSTIC_STATUS: begin
                nxt_rdata = diagnostic_status_word;
            end
            default: begin
                nxt_rdata = 8'h00;
            end
        endcase
    end

    // Read data is captured on the strobe and held until the next read.
    always_ff @(posedge CLK_SYS) begin
        if (SRST) begin
            REG_RDATA <= fmd_pkg::RST_READ_DATA;
            REG_RDATA_VALID <= 1'b0;
        end else begin
            REG_RDATA_VALID <= REG_RD;
            if (REG_RD) begin
                REG_RDATA <= nxt_rdata;
            end
        end
    end

    // =====================================================================
    // Fault classes and the fault line
    logic boost_cls, open_cls, gnd_cls, warn_cls, lshort_cls;
    logic nxt_fault, fault_ff;

    assign boost_cls = (boost_uv_ff | boost_ov_ff) & ~mask_ff[fmd_pkg::MSK_BOOST_FAULT];
    assign open_cls = (|open_ff) & ~mask_ff[fmd_pkg::MSK_OPEN_STRING];
    assign gnd_cls = (|gnd_ff) & ~mask_ff[fmd_pkg::MSK_GROUND_SHORT];
    assign warn_cls = temp_warn_ff & ~mask_ff[fmd_pkg::MSK_THERMAL_WARN];
    assign lshort_cls = (|lshort_ff) & ~mask_ff[fmd_pkg::MSK_LED_SHORT];

    assign nxt_fault = boost_cls | open_cls | gnd_cls | warn_cls | lshort_cls;

    // The line enable is registered so the pin never glitches.
    always_ff @(posedge CLK_SYS) begin
        if (SRST) begin
            fault_ff <= 1'b0;
        end else begin
            fault_ff <= nxt_fault;
        end
    end

    // Open drain: drive low while a fault stands, release otherwise.
    assign FAULT_LINE_N_O = 1'b0;
    assign FAULT_LINE_N_OE = fault_ff;
    assign FAULT_LINE_SENSE = line_s;

    // =====================================================================
    // Power control outputs
    // halt on range error
    assign HALT_OPERATION = ref_bad_ff;
    assign BOOST_DISABLE = boost_uv_ff;
    assign THERMAL_SHUTDOWN = shutdown_ff;

endmodule

`default_nettype wire

// [test/fmd_top_properties.sv]
// Concurrent checks on the ports of the fault mask and status block.
// Assumes it is bound into fmd_top, with one clock and a synchronous reset.
`default_nettype none

module fmd_top_properties (
    // Clock and reset
    input wire logic CLK_SYS,
    input wire logic SRST,
    // Register port
    input wire logic REG_RD,
    input wire logic [7:0] REG_RDATA,
    input wire logic REG_RDATA_VALID,
    // Detector levels
    input wire logic REF_CURRENT_BAD,
    input wire logic BOOST_UNDERVOLT_DET,
    input wire logic TEMP_ABOVE_SHUTDOWN,
    // Fault wire and power control
    input wire logic FAULT_LINE_N_I,
    input wire logic FAULT_LINE_N_O,
    input wire logic FAULT_LINE_SENSE,
    input wire logic HALT_OPERATION,
    input wire logic BOOST_DISABLE,
    input wire logic THERMAL_SHUTDOWN
);
    timeunit 1ns;
    timeprecision 1ps;

    // =====================================================================
    // Assertions
    // All checks share the system clock and pause while reset is high.
    default clocking cb @(posedge CLK_SYS);
    endclocking
    default disable iff (SRST);

    a_valid_follows_read: assert property (!$past(SRST) |-> REG_RDATA_VALID == $past(REG_RD))
        else $error("read valid does not follow the read strobe");
    a_rdata_held: assert property ((!$past(SRST) && !$past(REG_RD)) |-> $stable(REG_RDATA))
        else $error("read data moved without a read");
    a_halt_on_ref: assert property (REF_CURRENT_BAD [*5] |-> HALT_OPERATION)
        else $error("operation not halted on bad reference current");
    a_halt_released: assert property (!REF_CURRENT_BAD [*5] |-> !HALT_OPERATION)
        else $error("halt stays after reference current recovered");
    a_uv_disables: assert property (BOOST_UNDERVOLT_DET [*5] |-> BOOST_DISABLE)
        else $error("boost not disabled on undervoltage");
    a_uv_latched: assert property (BOOST_DISABLE |=> BOOST_DISABLE)
        else $error("boost disable dropped before reset");
    a_shutdown_set: assert property (TEMP_ABOVE_SHUTDOWN [*5] |-> THERMAL_SHUTDOWN)
        else $error("no shutdown on overtemperature");
    a_shutdown_latched: assert property (THERMAL_SHUTDOWN |=> THERMAL_SHUTDOWN)
        else $error("shutdown dropped before reset");
    a_drives_low_only: assert property (FAULT_LINE_N_O == 1'b0)
        else $error("fault wire driven high");
    a_sense_two_stages: assert property ((!$past(SRST) && !$past(SRST, 2))
        |-> FAULT_LINE_SENSE == $past(FAULT_LINE_N_I, 2))
        else $error("fault sense is not the wire two cycles back");
endmodule

bind fmd_top fmd_top_properties u_props (.CLK_SYS, .SRST, .REG_RD, .REG_RDATA,
    .REG_RDATA_VALID, .REF_CURRENT_BAD, .BOOST_UNDERVOLT_DET, .TEMP_ABOVE_SHUTDOWN,
    .FAULT_LINE_N_I, .FAULT_LINE_N_O, .FAULT_LINE_SENSE, .HALT_OPERATION,
    .BOOST_DISABLE, .THERMAL_SHUTDOWN);

`default_nettype wire

// [test/fmd_host_model.sv]
// Host model: register reads and writes plus the pulled-up fault wire.
// Assumes the block samples strobes on the rising clock edge.
`default_nettype none

module fmd_host_model (
    // Clock
    input wire logic clk,
    // Register port towards the block
    output logic [7:0] reg_addr,
    output logic reg_wr,
    output logic [7:0] reg_wdata,
    output logic reg_rd,
    input wire logic [7:0] reg_rdata,
    input wire logic reg_rdata_valid,
    // Open-drain fault wire
    input wire logic fault_n_o,
    input wire logic fault_n_oe,
    output logic fault_n_i
);
    timeunit 1ns;
    timeprecision 1ps;

    // The wire has a pull-up, so it reads high unless the block pulls it.
    assign fault_n_i = fault_n_oe ? fault_n_o : 1'b1;

    // Idle state of the port.
    initial begin
        reg_addr = 8'h00;
        reg_wr = 1'b0;
        reg_wdata = 8'h00;
        reg_rd = 1'b0;
    end

    // One write strobe; address and data are scrambled once released.
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clk);
        reg_wr <= 1'b0;
        reg_addr <= ~a;
        reg_wdata <= ~d;
    endtask

    // One read strobe; data counts only when valid stands the next cycle.
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk);
        reg_rd <= 1'b0;
        reg_addr <= ~a;
        #1;
        d = reg_rdata_valid ? reg_rdata : 8'hXX;
    endtask
endmodule

`default_nettype wire

// [test/tb_fmd_top.sv]
// Self-checking bench of the fault mask and status block.
// Assumes the host model in fmd_host_model and the package fmd_pkg.
`default_nettype none

module tb_fmd_top;
    timeunit 1ns;
    timeprecision 1ps;

    // =====================================================================
    // Signals
    typedef struct packed {
        logic [4:0] msk;
        logic [1:0] lvl;
        logic [3:0] opn;
        logic [3:0] sl;
        logic oe;
        logic [7:0] dg;
    } fmd_row_t;
    // Gate, {overvoltage, warning}, open and short flags, pin and status.
    localparam fmd_row_t ROWS [10] = '{
        '{5'h00, 2'h2, 4'h0, 4'h0, 1'b1, 8'h08}, '{5'h10, 2'h2, 4'h0, 4'h0, 1'b0, 8'h08},
        '{5'h00, 2'h0, 4'h8, 4'h0, 1'b1, 8'h00}, '{5'h08, 2'h0, 4'h8, 4'h0, 1'b0, 8'h00},
        '{5'h00, 2'h1, 4'h0, 4'h0, 1'b1, 8'h02}, '{5'h02, 2'h1, 4'h0, 4'h0, 1'b0, 8'h02},
        '{5'h00, 2'h0, 4'h0, 4'h1, 1'b1, 8'h00}, '{5'h01, 2'h0, 4'h0, 4'h1, 1'b0, 8'h00},
        '{5'h17, 2'h0, 4'h5, 4'hA, 1'b1, 8'h00}, '{5'h1F, 2'h3, 4'hF, 4'hF, 1'b0, 8'h0A}};
    logic clk = 1'b0;
    logic srst = 1'b1;
    logic ref_bad = 1'b0, uv = 1'b0, ov = 1'b0, warn = 1'b0, shut = 1'b0, startup = 1'b0;
    logic [3:0] opn = 4'h0, gnd = 4'h0, sl = 4'h0;
    logic [7:0] addr, wdata, rdata, d;
    logic wr, rd, valid, fl_i, fl_o, fl_oe, sense, halt, bdis, tsd;
    int mismatches = 0;
    int n_checks = 0;

    // =====================================================================
    // Clock, design and host
    always #20 clk = ~clk;

    fmd_top u_dut (.CLK_SYS(clk), .SRST(srst), .REG_ADDR(addr), .REG_WR(wr),
        .REG_WDATA(wdata), .REG_RD(rd), .REG_RDATA(rdata), .REG_RDATA_VALID(valid),
        .REF_CURRENT_BAD(ref_bad), .BOOST_UNDERVOLT_DET(uv), .BOOST_OVERVOLT_DET(ov),
        .TEMP_ABOVE_WARN(warn), .TEMP_ABOVE_SHUTDOWN(shut), .STARTUP_PHASE(startup),
        .CH_OPEN_DET(opn), .CH_GND_SHORT_DET(gnd), .CH_LED_SHORT_DET(sl),
        .FAULT_LINE_N_I(fl_i), .FAULT_LINE_N_O(fl_o), .FAULT_LINE_N_OE(fl_oe),
        .FAULT_LINE_SENSE(sense), .HALT_OPERATION(halt), .BOOST_DISABLE(bdis),
        .THERMAL_SHUTDOWN(tsd));

    fmd_host_model host (.clk(clk), .reg_addr(addr), .reg_wr(wr), .reg_wdata(wdata),
        .reg_rd(rd), .reg_rdata(rdata), .reg_rdata_valid(valid), .fault_n_o(fl_o),
        .fault_n_oe(fl_oe), .fault_n_i(fl_i));

    // =====================================================================
    // Helpers
    // Compares one byte, counting every comparison and every mismatch.
    task automatic chk(input string nm, input logic [7:0] got, input logic [7:0] exp);
        n_checks++;
        if (got !== exp) begin
            mismatches++;
            $display("[ERR] %s expected %h seen %h", nm, exp, got);
        end
    endtask

    // Waits some edges, then lets their updates settle.
    task automatic wt(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask

    // Prints the counts and the verdict, then ends the run.
    task automatic give_verdict();
        $display("checks %0d mismatches %0d", n_checks, mismatches);
        if (mismatches == 0 && n_checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    // The whole run needs well under a thousand cycles.
    initial begin
        repeat (3000) @(posedge clk);
        mismatches++;
        give_verdict();
    end

    // =====================================================================
    // Tests
    initial begin
        repeat (3) @(posedge clk);
        srst <= 1'b0;
        host.rd(fmd_pkg::OFS_DIAGNOSTIC_STATUS, d);
        chk("status_after_reset", d, 8'h04);
        foreach (ROWS[i]) begin
            host.wr(fmd_pkg::OFS_FAULT_PIN_MASK, {3'h0, ROWS[i].msk});
            @(posedge clk) {ov, warn, opn, sl} <= {ROWS[i].lvl, ROWS[i].opn, ROWS[i].sl};
            wt(7);
            chk("fault_oe", {7'h00, fl_oe}, {7'h00, ROWS[i].oe});
            chk("fault_sense", {7'h00, sense}, {7'h00, ~ROWS[i].oe});
            host.rd(fmd_pkg::OFS_DIAGNOSTIC_STATUS, d);
            chk("status", d, ROWS[i].dg);
            host.rd(fmd_pkg::OFS_OPEN_FLAGS, d);
            chk("open_flags", d, {4'h0, ROWS[i].opn});
            host.rd(fmd_pkg::OFS_SHORT_FLAGS, d);
            chk("short_flags", d, {4'h0, ROWS[i].sl});
            @(posedge clk) {ov, warn, opn, sl} <= 10'h000;
            wt(7);
            $display("row %0d done", i);
        end
        // Upper mask bits are dropped and unmapped reads give zero.
        host.wr(fmd_pkg::OFS_FAULT_PIN_MASK, 8'hFF);
        host.rd(fmd_pkg::OFS_FAULT_PIN_MASK, d);
        chk("mask_width", d, 8'h1F);
        host.rd(8'h20, d);
        chk("unmapped", d, 8'h00);
        $display("register access done");
        // Ground shorts count only during startup and then stay.
        host.wr(fmd_pkg::OFS_FAULT_PIN_MASK, 8'h1B);
        @(posedge clk) gnd <= 4'h2;
        wt(7);
        host.rd(fmd_pkg::OFS_GND_FLAGS, d);
        chk("gnd_outside_startup", d, 8'h00);
        @(posedge clk) startup <= 1'b1;
        wt(7);
        @(posedge clk) {startup, gnd} <= 5'h00;
        wt(7);
        host.rd(fmd_pkg::OFS_GND_FLAGS, d);
        chk("gnd_sticky", d, 8'h02);
        chk("gnd_fault_oe", {7'h00, fl_oe}, 8'h01);
        host.wr(fmd_pkg::OFS_FAULT_PIN_MASK, 8'h1F);
        wt(3);
        chk("gnd_masked_oe", {7'h00, fl_oe}, 8'h00);
        $display("ground short done");
        // Bad reference current halts only while it lasts.
        @(posedge clk) ref_bad <= 1'b1;
        wt(7);
        chk("halt_set", {7'h00, halt}, 8'h01);
        host.rd(fmd_pkg::OFS_DIAGNOSTIC_STATUS, d);
        chk("status_ref", d, 8'h20);
        @(posedge clk) ref_bad <= 1'b0;
        wt(7);
        chk("halt_clear", {7'h00, halt}, 8'h00);
        $display("reference current done");
        // Undervoltage and shutdown stay latched after a short pulse.
        host.wr(fmd_pkg::OFS_FAULT_PIN_MASK, 8'h0F);
        @(posedge clk) {uv, shut} <= 2'h3;
        wt(7);
        @(posedge clk) {uv, shut} <= 2'h0;
        wt(7);
        chk("boost_disable", {7'h00, bdis}, 8'h01);
        chk("shutdown", {7'h00, tsd}, 8'h01);
        chk("uv_fault_oe", {7'h00, fl_oe}, 8'h01);
        host.rd(fmd_pkg::OFS_DIAGNOSTIC_STATUS, d);
        chk("status_latched", d, 8'h11);
        host.wr(fmd_pkg::OFS_FAULT_PIN_MASK, 8'h14);
        wt(3);
        chk("uv_masked_oe", {7'h00, fl_oe}, 8'h00);
        $display("latched faults done");
        // A second reset restores every value.
        @(posedge clk) srst <= 1'b1;
        wt(3);
        @(posedge clk) srst <= 1'b0;
        #1;
        chk("boost_disable_rst", {7'h00, bdis}, 8'h00);
        host.rd(fmd_pkg::OFS_FAULT_PIN_MASK, d);
        chk("mask_rst", d, 8'h00);
        host.rd(fmd_pkg::OFS_DIAGNOSTIC_STATUS, d);
        chk("status_rst", d, 8'h04);
        host.rd(fmd_pkg::OFS_DIAGNOSTIC_STATUS, d);
        chk("status_reread", d, 8'h00);
        host.rd(fmd_pkg::OFS_GND_FLAGS, d);
        chk("gnd_rst", d, 8'h00);
        $display("reset done");
        give_verdict();
    end
endmodule

`default_nettype wire
